// file: mcse_pkg.sv
// mcse_pkg: offsets, field positions, reset values of the msi config export block
// assumes a 32-bit apb slave with word aligned registers
package mcse_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [11:0] MCSE_OFF_MSI_DATA = 12'h000;
   localparam logic [11:0] MCSE_OFF_BUSDEV   = 12'h004;
   localparam logic [11:0] MCSE_OFF_MSI_CSR  = 12'h008;
   localparam logic [11:0] MCSE_OFF_CAPS     = 12'h00C;
   // ------------------------------------------------------------
   // control word field positions
   // ------------------------------------------------------------
   localparam int MCSE_BIT_MASK_CAP  = 8;
   localparam int MCSE_BIT_ADDR64    = 7;
   localparam int MCSE_MME_LSB       = 4;
   localparam int MCSE_MMC_LSB       = 1;
   localparam int MCSE_BIT_ENABLE    = 0;
   localparam logic [2:0] MCSE_VEC_MAX_CODE = 3'h5;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] MCSE_RST_MSI_DATA = 16'h0000;
   localparam logic [12:0] MCSE_RST_BUSDEV   = 13'h0000;
   localparam logic [2:0]  MCSE_RST_MME      = 3'h0;
   localparam logic        MCSE_RST_ENABLE   = 1'b0;
   localparam logic [2:0]  MCSE_RST_MMC      = 3'h0;
   localparam logic        MCSE_RST_ADDR64   = 1'b1;
endpackage

// file: mcse_csr_pack.sv
// mcse_csr_pack: assembles the 16-bit msi control and status word
// assumes field inputs come from registers on the same clock
`timescale 1ns/10ps
`default_nettype none
module mcse_csr_pack (
   input  wire logic        addr64_i,
   input  wire logic [2:0]  mme_i,
   input  wire logic [2:0]  mmc_i,
   input  wire logic        enable_i,
   output logic      [15:0] csr_o
);
   always_comb begin
      csr_o = 16'h0000;
      csr_o[15:9] = 7'h00;
      csr_o[mcse_pkg::MCSE_BIT_MASK_CAP] = 1'b0;
      csr_o[mcse_pkg::MCSE_BIT_ADDR64] = addr64_i;
      csr_o[mcse_pkg::MCSE_MME_LSB +: 3] = mme_i;
      csr_o[mcse_pkg::MCSE_MMC_LSB +: 3] = mmc_i;
      csr_o[mcse_pkg::MCSE_BIT_ENABLE] = enable_i;
   end
endmodule // mcse_csr_pack
`default_nettype wire

// file: mcse_top.sv
// mcse_top: apb register bank exporting msi config state to application logic
// assumes an apb master on mclk_i; outputs feed fabric logic on the same clock
//
// Behaviour
// - msi_data_o carries the 16-bit msi message data programmed by software.
// - busdev_o carries the 13-bit bus and device number, captured or programmed.
// - control bit 8, per vector mask capability, always reads zero.
// - control bit 7 is one only when 64-bit message addresses can be sent.
// - bits 6 to 4 give allocated vectors, codes 110 and 111 reserved.
// - bits 3 to 1 report requested vectors for software, code 110 reserved.
// - while bit 0 is zero no msi may be sent, so msi_allowed_o stays low.
// - msi_csr_o drives the control word continuously to the application.
`timescale 1ns/10ps
`default_nettype none
module mcse_top (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        busdev_cap_vld_i,
   input  wire logic [12:0] busdev_cap_i,
   output logic      [15:0] msi_data_o,
   output logic      [12:0] busdev_o,
   output logic      [15:0] msi_csr_o,
   output logic             msi_allowed_o,
   output logic      [5:0]  msi_vec_cnt_o
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [15:0] data_r,   data_nxt;
   logic [12:0] busdev_r, busdev_nxt;
   logic [2:0]  mme_r,    mme_nxt;
   logic        en_r,     en_nxt;
   logic [2:0]  mmc_r,    mmc_nxt;
   logic        a64_r,    a64_nxt;
   logic [31:0] rdata_r,  rdata_nxt;
   logic        err_r,    err_nxt;
   logic [15:0] csr_w;
   logic        acc_w;
   logic        wr_w;
   logic        wr_data_w;
   logic        wr_busdev_w;
   logic        wr_csr_w;
   logic        wr_caps_w;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = hit(a, mcse_pkg::MCSE_OFF_MSI_DATA) | hit(a, mcse_pkg::MCSE_OFF_BUSDEV)
             | hit(a, mcse_pkg::MCSE_OFF_MSI_CSR) | hit(a, mcse_pkg::MCSE_OFF_CAPS);
   endfunction

   // zero wait state slave: access phase completes in one cycle
   assign acc_w = psel_i & ~penable_i;
   assign wr_w  = psel_i & penable_i & pwrite_i & mapped(paddr_i);

   // ------------------------------------------------------------
   // write strobes
   // ------------------------------------------------------------
   // decoded once so every group sees the same access edge
   assign wr_data_w   = wr_w & hit(paddr_i, mcse_pkg::MCSE_OFF_MSI_DATA);
   assign wr_busdev_w = wr_w & hit(paddr_i, mcse_pkg::MCSE_OFF_BUSDEV);
   assign wr_csr_w    = wr_w & hit(paddr_i, mcse_pkg::MCSE_OFF_MSI_CSR) & pstrb_i[0];
   assign wr_caps_w   = wr_w & hit(paddr_i, mcse_pkg::MCSE_OFF_CAPS) & pstrb_i[0];

   // ------------------------------------------------------------
   // message data group
   // ------------------------------------------------------------
   // byte lanes let software patch halves
   always_comb begin
      data_nxt = data_r;
      if (wr_data_w) begin
         if (pstrb_i[0]) begin
            data_nxt[7:0] = pwdata_i[7:0];
         end
         if (pstrb_i[1]) begin
            data_nxt[15:8] = pwdata_i[15:8];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         data_r <= mcse_pkg::MCSE_RST_MSI_DATA;
      end else begin
         data_r <= data_nxt;
      end
   end

   // ------------------------------------------------------------
   // bus and device number group
   // ------------------------------------------------------------
   always_comb begin
      busdev_nxt = busdev_r;
      if (wr_busdev_w) begin
         if (pstrb_i[0]) begin
            busdev_nxt[7:0] = pwdata_i[7:0];
         end
         if (pstrb_i[1]) begin
            busdev_nxt[12:8] = pwdata_i[12:8];
         end
      end
      if (busdev_cap_vld_i) begin
         busdev_nxt = busdev_cap_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         busdev_r <= mcse_pkg::MCSE_RST_BUSDEV;
      end else begin
         busdev_r <= busdev_nxt;
      end
   end

   // ------------------------------------------------------------
   // control word group
   // ------------------------------------------------------------
   always_comb begin
      mme_nxt = mme_r;
      en_nxt  = en_r;
      mmc_nxt = mmc_r;
      a64_nxt = a64_r;
      if (wr_csr_w) begin
         mme_nxt = pwdata_i[mcse_pkg::MCSE_MME_LSB +: 3];
         en_nxt  = pwdata_i[mcse_pkg::MCSE_BIT_ENABLE];
      end
      if (wr_caps_w) begin
         mmc_nxt = pwdata_i[mcse_pkg::MCSE_MMC_LSB +: 3];
         a64_nxt = pwdata_i[mcse_pkg::MCSE_BIT_ADDR64];
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mme_r <= mcse_pkg::MCSE_RST_MME;
         en_r  <= mcse_pkg::MCSE_RST_ENABLE;
         mmc_r <= mcse_pkg::MCSE_RST_MMC;
         a64_r <= mcse_pkg::MCSE_RST_ADDR64;
      end else begin
         mme_r <= mme_nxt;
         en_r  <= en_nxt;
         mmc_r <= mmc_nxt;
         a64_r <= a64_nxt;
      end
   end

   // ------------------------------------------------------------
   // control word assembly
   // ------------------------------------------------------------
   mcse_csr_pack u_pack (
      .addr64_i (a64_r),
      .mme_i    (mme_r),
      .mmc_i    (mmc_r),
      .enable_i (en_r),
      .csr_o    (csr_w)
   );

   // ------------------------------------------------------------
   // apb read path
   // ------------------------------------------------------------
   // read data captured in setup so it is stable for the access phase
   always_comb begin
      rdata_nxt = rdata_r;
      err_nxt   = err_r;
      if (acc_w) begin
         rdata_nxt = 32'h0000_0000;
         err_nxt   = ~mapped(paddr_i);
         if (hit(paddr_i, mcse_pkg::MCSE_OFF_MSI_DATA)) begin
            rdata_nxt[15:0] = data_r;
         end
         if (hit(paddr_i, mcse_pkg::MCSE_OFF_BUSDEV)) begin
            rdata_nxt[12:0] = busdev_r;
         end
         if (hit(paddr_i, mcse_pkg::MCSE_OFF_MSI_CSR) || hit(paddr_i, mcse_pkg::MCSE_OFF_CAPS)) begin
            rdata_nxt[15:0] = csr_w;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_r <= 32'h0000_0000;
         err_r   <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         err_r   <= err_nxt;
      end
   end

   assign prdata_o  = rdata_r;
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i & penable_i & err_r;

   // ------------------------------------------------------------
   // application outputs
   // ------------------------------------------------------------
   // message data out
   assign msi_data_o = data_r;
   assign busdev_o   = busdev_r;
   assign msi_csr_o  = csr_w;
   assign msi_allowed_o = en_r;
   // reserved codes give one vector, a limit the application must keep
   assign msi_vec_cnt_o = (mme_r <= mcse_pkg::MCSE_VEC_MAX_CODE) ? (6'h01 << mme_r) : 6'h01;
endmodule // mcse_top
`default_nettype wire

// file: mcse_top_properties.sv
// mcse_top_properties: port timing checks for mcse_top
// assumes one clock, async active low reset, pready tied high
`timescale 1ns/10ps
`default_nettype none
module mcse_top_properties (
   input wire logic        mclk_i,
   input wire logic        rst_b_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0]  pstrb_i,
   input wire logic        busdev_cap_vld_i,
   input wire logic [12:0] busdev_cap_i,
   input wire logic [15:0] msi_data_o,
   input wire logic [12:0] busdev_o,
   input wire logic [15:0] msi_csr_o,
   input wire logic        msi_allowed_o,
   input wire logic [5:0]  msi_vec_cnt_o
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   // zero wait slave, so every access phase completes
   wire logic wr = psel_i && penable_i && pwrite_i;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   AST_MASK: assert property (msi_csr_o[8] == 1'b0) else $error("mask bit set");
   AST_RSVD: assert property (msi_csr_o[15:9] == 7'h00) else $error("reserved set");
   AST_ALLOW: assert property (msi_allowed_o == msi_csr_o[0]) else $error("allow wrong");
   AST_VEC: assert property (msi_vec_cnt_o == (msi_csr_o[6:4] > 3'h5 ? 6'h01 :
      6'h01 << msi_csr_o[6:4])) else $error("vector count wrong");
   AST_DATA: assert property (wr && pstrb_i[1:0] == 2'h3 && paddr_i == 12'h000 |=>
      msi_data_o == $past(pwdata_i[15:0])) else $error("data not taken");
   AST_BUSDEV: assert property (busdev_cap_vld_i |=> busdev_o == $past(busdev_cap_i))
      else $error("capture lost");
   AST_ALLOC: assert property (wr && pstrb_i[0] && paddr_i == 12'h008 |=>
      {msi_csr_o[6:4], msi_csr_o[0]} == {$past(pwdata_i[6:4]), $past(pwdata_i[0])})
      else $error("alloc not taken");
   AST_REQ: assert property (wr && pstrb_i[0] && paddr_i == 12'h00C |=>
      {msi_csr_o[7], msi_csr_o[3:1]} == {$past(pwdata_i[7]), $past(pwdata_i[3:1])})
      else $error("request not taken");
   AST_STRB: assert property (wr && !pstrb_i[0] && paddr_i[11:3] == 9'h001 |=>
      $stable(msi_csr_o)) else $error("upper lane write landed");
   AST_HOLD: assert property (!wr |=> $stable(msi_csr_o)) else $error("word moved");
   C_ENA: cover property (wr && paddr_i == 12'h008 ##1 msi_allowed_o);
   C_CAP: cover property (busdev_cap_vld_i);
   C_V32: cover property (msi_vec_cnt_o == 6'h20);
endmodule // mcse_top_properties
bind mcse_top mcse_top_properties i_props (
   .mclk_i           (mclk_i),
   .rst_b_i          (rst_b_i),
   .psel_i           (psel_i),
   .penable_i        (penable_i),
   .pwrite_i         (pwrite_i),
   .paddr_i          (paddr_i),
   .pwdata_i         (pwdata_i),
   .pstrb_i          (pstrb_i),
   .busdev_cap_vld_i (busdev_cap_vld_i),
   .busdev_cap_i     (busdev_cap_i),
   .msi_data_o       (msi_data_o),
   .busdev_o         (busdev_o),
   .msi_csr_o        (msi_csr_o),
   .msi_allowed_o    (msi_allowed_o),
   .msi_vec_cnt_o    (msi_vec_cnt_o)
);
`default_nettype wire

// file: mcse_app_model.sv
// mcse_app_model: application side raising msi requests
// assumes mcse_top outputs on the same clock
`timescale 1ns/10ps
`default_nettype none
module mcse_app_model (
   input  wire logic       mclk_i,
   input  wire logic       rst_b_i,
   input  wire logic       allowed_i,
   input  wire logic [5:0] vec_cnt_i,
   output logic            req_o,
   output logic      [5:0] vec_o
);
   // ------------------------------------------------------------
   // requests
   // ------------------------------------------------------------
   logic [31:0] rnd_r;
   // one fresh random word a cycle drives both outputs
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rnd_r <= 32'h0000_0000;
      end else begin
         rnd_r <= $urandom;
      end
   end
   assign vec_o = 6'(rnd_r % 32'(vec_cnt_i));
   // bit 30 stands for the application's own vector mask
   // gated by the live enable, never a stale grant
   assign req_o = allowed_i & rnd_r[31] & ~rnd_r[30];
endmodule // mcse_app_model
`default_nettype wire

// file: tb.sv
// tb: apb stimulus and read scoreboard for mcse_top
// assumes a zero wait slave and 250 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        mclk_i, rst_b_i, psel_i, penable_i, pwrite_i, busdev_cap_vld_i, req, en, a64;
   logic        pready_o, pslverr_o, msi_allowed_o;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, d;
   logic [3:0]  pstrb_i, strb;
   logic [12:0] busdev_cap_i, busdev_o;
   logic [15:0] msi_data_o, msi_csr_o;
   logic [5:0]  msi_vec_cnt_o, vec;
   logic [2:0]  mme, mmc;
   logic [32:0] q[$];
   int          fail_count, samples_checked;
   mcse_top i_dut (
      .mclk_i           (mclk_i),
      .rst_b_i          (rst_b_i),
      .psel_i           (psel_i),
      .penable_i        (penable_i),
      .pwrite_i         (pwrite_i),
      .paddr_i          (paddr_i),
      .pwdata_i         (pwdata_i),
      .pstrb_i          (pstrb_i),
      .prdata_o         (prdata_o),
      .pready_o         (pready_o),
      .pslverr_o        (pslverr_o),
      .busdev_cap_vld_i (busdev_cap_vld_i),
      .busdev_cap_i     (busdev_cap_i),
      .msi_data_o       (msi_data_o),
      .busdev_o         (busdev_o),
      .msi_csr_o        (msi_csr_o),
      .msi_allowed_o    (msi_allowed_o),
      .msi_vec_cnt_o    (msi_vec_cnt_o)
   );
   mcse_app_model i_app (
      .mclk_i    (mclk_i),
      .rst_b_i   (rst_b_i),
      .allowed_i (msi_allowed_o),
      .vec_cnt_i (msi_vec_cnt_o),
      .req_o     (req),
      .vec_o     (vec)
   );
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
      input logic [32:0] e);
      @(posedge mclk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= wd;
      pstrb_i <= w ? strb : 4'h0;
      if (!w) q.push_back(e);
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do @(posedge mclk_i); while (pready_o !== 1'b1);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      #1;
   endtask
   function automatic logic [32:0] ecsr();
      return {24'h0, a64, mme, mmc, en};
   endfunction
   function automatic logic [5:0] ecnt();
      return (mme > 3'h5) ? 6'h01 : 6'h01 << mme;
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge mclk_i) begin
      if (psel_i && penable_i && pready_o && !pwrite_i && q.size() > 0)
         chk({pslverr_o, prdata_o}, q.pop_front());
      // far side requests stay inside the grant
      if (rst_b_i && req) begin
         chk(33'(en), 33'h1);
         chk(33'(vec < ecnt()), 33'h1);
      end
   end
   initial begin
      repeat (2000) @(posedge mclk_i);
      fail_count++;
      print_verdict();
   end
   initial begin
      {rst_b_i, psel_i, penable_i, pwrite_i, busdev_cap_vld_i} = 5'h00;
      {paddr_i, pwdata_i, busdev_cap_i} = 57'h0;
      {pstrb_i, strb} = 8'hFF;
      {mme, mmc, en, a64} = 8'h01;
      void'($urandom(32'h9D598A34));
      repeat (4) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      chk(33'(msi_csr_o), ecsr());
      chk(33'(msi_data_o), 33'(mcse_pkg::MCSE_RST_MSI_DATA));
      chk(33'(busdev_o), 33'(mcse_pkg::MCSE_RST_BUSDEV));
      chk(33'(msi_allowed_o), 33'h0);
      chk(33'(msi_vec_cnt_o), 33'h1);
      d = $urandom;
      apb(1'b1, mcse_pkg::MCSE_OFF_MSI_DATA, d, 33'h0);
      chk(33'(msi_data_o), 33'(d[15:0]));
      apb(1'b0, mcse_pkg::MCSE_OFF_MSI_DATA, 32'h0, 33'(d[15:0]));
      // junk in read-only bits must not land
      for (int i = 0; i < 8; i++) begin
         d = $urandom;
         apb(1'b1, mcse_pkg::MCSE_OFF_MSI_CSR, {d[31:7], 3'(i), d[3:0]}, 33'h0);
         mme = 3'(i);
         en = d[0];
         chk(33'(msi_csr_o), ecsr());
         chk(33'(msi_vec_cnt_o), 33'(i > 5 ? 1 : 1 << i));
         chk(33'(msi_allowed_o), 33'(en));
      end
      // upper lanes only: control word must hold
      strb = 4'hE;
      apb(1'b1, mcse_pkg::MCSE_OFF_MSI_CSR, 32'(~ecsr()), 33'h0);
      strb = 4'hF;
      chk(33'(msi_csr_o), ecsr());
      for (int i = 0; i < 7; i++) begin
         d = $urandom;
         mmc = 3'(i);
         a64 = d[7];
         apb(1'b1, mcse_pkg::MCSE_OFF_CAPS, {d[31:4], mmc, d[0]}, 33'h0);
         apb(1'b0, mcse_pkg::MCSE_OFF_CAPS, 32'h0, ecsr());
      end
      @(posedge mclk_i);
      busdev_cap_i <= d[12:0];
      busdev_cap_vld_i <= 1'b1;
      @(posedge mclk_i);
      busdev_cap_vld_i <= 1'b0;
      #1;
      chk(33'(busdev_o), 33'(d[12:0]));
      d = ~d;
      apb(1'b1, mcse_pkg::MCSE_OFF_BUSDEV, 32'(d[12:0]), 33'h0);
      apb(1'b0, mcse_pkg::MCSE_OFF_BUSDEV, 32'h0, 33'(d[12:0]));
      apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
      print_verdict();
   end
endmodule // tb
`default_nettype wire
